// ---- design/slbi_pkg.sv ----
package slbi_pkg;
  localparam int unsigned    CLK_HZ          = 25000000;
  localparam int unsigned    SCL_HZ          = 100000;
  // scl quarter period in system cycles, rounded up so the rate never passes standard mode
  localparam int unsigned    QTR_CYC         = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
  localparam logic [7:0]     ADDR_WR         = 8'hd2;
  localparam logic [7:0]     ADDR_RD         = 8'hd3;
  localparam int unsigned    NUM_CFG         = 6;
  localparam logic [7:0]     BYTE_CNT        = 8'h06;
  localparam int unsigned    STRAP_W         = 5;
  localparam logic [47:0]    CFG_RESET       = 48'h0000_0000_0000;
  localparam logic [2:0]     PHASE_CMD       = 3'h0;
  localparam logic [2:0]     PHASE_CNT       = 3'h1;
  localparam logic [2:0]     PHASE_DATA      = 3'h2;
  localparam logic [3:0]     BIT_LAST        = 4'h7;
  localparam logic [3:0]     BIT_ACK         = 4'h8;
  typedef enum logic [1:0] {SLBI_OP_WRITE, SLBI_OP_READ, SLBI_OP_RSV2, SLBI_OP_RSV3} slbi_op_t;
endpackage

// ---- design/slbi_if.sv ----
`timescale 1ns/1ps
interface slbi_if;
  logic scl;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic sda;
  // open drain wire with pull-up
  assign sda = !((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o));
  modport host (output scl, output sda_h_o, output sda_h_oe, input sda);
  modport dev  (input scl, output sda_d_o, output sda_d_oe, input sda);
endinterface

// ---- design/slbi_device.sv ----
`timescale 1ns/1ps
// Summary of operation
// (RQ1) straps sampled into 5-bit latch during power-up
// (RQ2) after reset, pins drive clocks, straps kept
// (RQ3) pin high latches one, low latches zero
// (RQ4) host starts every transaction with start
// (RQ5) write address d2 acknowledged
// (RQ6) command byte acknowledged
// (RQ7) byte count acknowledged before data
// (RQ8) data bytes 0..5 ascending, each acknowledged
// (RQ9) host ends write with stop
// (RQ10) read address d3 acknowledged
// (RQ11) device sends byte count first
// (RQ12) then returns bytes 0..5 ascending
// (RQ13) host acknowledges every returned byte
// (RQ14) host ends read with stop
// (RQ15) command and count contents discarded
// (RQ16) writes load bytes until stop
// (RQ17) host clock at most 100 kbit/s
// (RQ18) power-on loads default configuration
// (RQ19) release sda on host ack; ignore other addresses
module slbi_device
  import slbi_pkg::*;
(
  input  wire logic               i_clock,
  input  wire logic               i_arst_n,
  slbi_if.dev                     bus,
  input  wire logic [STRAP_W-1:0] i_strap_pin,
  input  wire logic [STRAP_W-1:0] i_clk_src,
  output logic      [STRAP_W-1:0] o_pin_out,
  output logic      [STRAP_W-1:0] o_pin_oe,
  output logic      [STRAP_W-1:0] o_strap,
  output logic      [47:0]        o_cfg
);
  typedef enum logic [2:0] {SLBI_IDLE, SLBI_ADDR, SLBI_RX, SLBI_TX, SLBI_IGNORE} slbi_dst_t;

  logic [STRAP_W-1:0] strap_s1_q, strap_s2_q, strap_q, strap_d;
  logic               por_q, por_d;
  logic [1:0]         scl_s_q, sda_s_q;
  logic               scl_q, sda_q;
  slbi_dst_t          st_q, st_d;
  logic [3:0]         bit_q, bit_d;
  logic [7:0]         sh_q, sh_d;
  logic [3:0]         idx_q, idx_d;
  logic [47:0]        cfg_q, cfg_d;
  logic               oe_q, oe_d;
  logic               rd_q, rd_d;
  logic               rise, fall, start, stop;
  logic [7:0]         tx_byte;

  // strap latch, captured on the first edge after reset release
  always_comb begin
    strap_d = strap_q;
    por_d   = 1'b1;
    if (!por_q) begin
      strap_d = strap_s2_q; // see (RQ1) see (RQ3)
    end
  end
  // pin sync runs through reset so the first edge after release sees the real strap level
  always_ff @(posedge i_clock) begin
    strap_s1_q <= i_strap_pin;
    strap_s2_q <= strap_s1_q;
  end
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strap_q    <= '0;
      por_q      <= 1'b0;
    end else begin
      strap_q    <= strap_d;
      por_q      <= por_d;
    end
  end
  assign o_strap   = strap_q;
  assign o_pin_oe  = {STRAP_W{por_q}}; // see (RQ2)
  assign o_pin_out = por_q ? i_clk_src : '0; // see (RQ2)

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_s_q <= 2'b11;
      sda_s_q <= 2'b11;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], bus.scl};
      sda_s_q <= {sda_s_q[0], bus.sda};
      scl_q   <= scl_s_q[1];
      sda_q   <= sda_s_q[1];
    end
  end
  assign rise  = scl_s_q[1] && !scl_q;
  assign fall  = !scl_s_q[1] && scl_q;
  assign start = scl_s_q[1] && scl_q && sda_q && !sda_s_q[1];
  assign stop  = scl_s_q[1] && scl_q && !sda_q && sda_s_q[1];
  assign tx_byte = (idx_q == 4'h0) ? BYTE_CNT : cfg_q[(idx_q - 4'h1) * 8 +: 8];

  always_comb begin
    st_d  = st_q;
    bit_d = bit_q;
    sh_d  = sh_q;
    idx_d = idx_q;
    cfg_d = cfg_q;
    oe_d  = oe_q;
    rd_d  = rd_q;
    if (start) begin // see (RQ4)
      st_d  = SLBI_ADDR;
      bit_d = '1; // the start's own scl fall wraps this to bit 0
      oe_d  = 1'b0;
    end else if (stop) begin // see (RQ9) see (RQ14) see (RQ16)
      st_d = SLBI_IDLE;
      oe_d = 1'b0;
    end else begin
      unique case (st_q)
        SLBI_IDLE, SLBI_IGNORE: begin
          oe_d = 1'b0; // see (RQ19)
        end
        SLBI_ADDR, SLBI_RX: begin
          if (rise && bit_q <= BIT_LAST) begin
            sh_d = {sh_q[6:0], sda_q};
          end
          if (fall) begin
            if (bit_q == BIT_LAST) begin
              if (st_q == SLBI_ADDR && sh_q != ADDR_WR && sh_q != ADDR_RD) begin
                st_d = SLBI_IGNORE; // see (RQ19)
              end else begin
                oe_d = 1'b1; // see (RQ5) see (RQ6) see (RQ7) see (RQ8) see (RQ10)
                bit_d = BIT_ACK;
              end
            end else if (bit_q == BIT_ACK) begin
              oe_d  = 1'b0;
              bit_d = '0;
              if (st_q == SLBI_ADDR) begin
                rd_d  = sh_q[0];
                idx_d = rd_d ? 4'h0 : 4'(PHASE_CMD);
                st_d  = rd_d ? SLBI_TX : SLBI_RX;
                if (rd_d) begin
                  oe_d = ~BYTE_CNT[7]; // see (RQ11)
                end
              end else begin
                if (idx_q >= 4'(PHASE_DATA) && idx_q < 4'(PHASE_DATA) + 4'(NUM_CFG)) begin
                  cfg_d[(idx_q - 4'(PHASE_DATA)) * 8 +: 8] = sh_q; // see (RQ8) see (RQ15)
                end
                if (idx_q < 4'(PHASE_DATA) + 4'(NUM_CFG)) begin
                  idx_d = idx_q + 4'h1;
                end
              end
            end else begin
              bit_d = bit_q + 4'h1;
            end
          end
        end
        SLBI_TX: begin
          if (rise && bit_q == BIT_ACK && sda_q) begin
            st_d = SLBI_IGNORE; // host nack ends the read
          end
          if (fall) begin
            if (bit_q == BIT_LAST) begin
              oe_d  = 1'b0; // see (RQ19)
              bit_d = BIT_ACK;
            end else if (bit_q == BIT_ACK) begin
              bit_d = '0;
              if (idx_q < 4'(NUM_CFG)) begin
                idx_d = idx_q + 4'h1; // see (RQ12)
                oe_d  = ~cfg_q[idx_q * 8 + 7];
              end else begin
                st_d = SLBI_IGNORE; // last byte sent, sda left free for the stop
              end
            end else begin
              bit_d = bit_q + 4'h1;
              oe_d  = ~tx_byte[3'(BIT_LAST - bit_d)];
            end
          end
        end
        default: st_d = SLBI_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q  <= SLBI_IDLE;
      bit_q <= '0;
      sh_q  <= '0;
      idx_q <= '0;
      cfg_q <= CFG_RESET; // see (RQ18)
      oe_q  <= 1'b0;
      rd_q  <= 1'b0;
    end else begin
      st_q  <= st_d;
      bit_q <= bit_d;
      sh_q  <= sh_d;
      idx_q <= idx_d;
      cfg_q <= cfg_d;
      oe_q  <= oe_d;
      rd_q  <= rd_d;
    end
  end
  assign bus.sda_d_o  = 1'b0;
  assign bus.sda_d_oe = oe_q;
  assign o_cfg        = cfg_q;
endmodule // slbi_device

// ---- design/slbi_host.sv ----
`timescale 1ns/1ps
module slbi_host
  import slbi_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_arst_n,
  slbi_if.host             bus,
  input  wire logic        i_go,
  input  wire slbi_op_t    i_op,
  input  wire logic [47:0] i_wdata,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_nack,
  output logic [47:0]      o_rdata,
  output logic [7:0]       o_rcount
);
  typedef enum logic [2:0] {SLBH_IDLE, SLBH_START, SLBH_BYTE, SLBH_STOP, SLBH_END} slbh_st_t;

  slbh_st_t    st_q, st_d;
  logic [7:0]  div_q, div_d;
  logic [1:0]  ph_q, ph_d;
  logic [3:0]  bit_q, bit_d;
  logic [3:0]  n_q, n_d;
  logic [7:0]  sh_q, sh_d;
  logic        rd_q, rd_d, scl_q, scl_d, sdo_q, sdo_d, nack_q, nack_d, done_q, done_d;
  logic [47:0] wd_q, wd_d, rdat_q, rdat_d;
  logic [7:0]  cnt_q, cnt_d;
  logic        tick;

  assign tick = (div_q == 8'(QTR_CYC - 1)); // see (RQ17)

  always_comb begin
    st_d = st_q; div_d = tick ? '0 : div_q + 8'h01; ph_d = ph_q; bit_d = bit_q; n_d = n_q;
    sh_d = sh_q; rd_d = rd_q; scl_d = scl_q; sdo_d = sdo_q; nack_d = nack_q; done_d = 1'b0;
    wd_d = wd_q; rdat_d = rdat_q; cnt_d = cnt_q;
    unique case (st_q)
      SLBH_IDLE: begin
        scl_d = 1'b1; sdo_d = 1'b1;
        if (i_go) begin
          st_d = SLBH_START; rd_d = (i_op == SLBI_OP_READ); wd_d = i_wdata; nack_d = 1'b0;
          ph_d = '0; div_d = '0;
        end
      end
      SLBH_START: if (tick) begin
        ph_d = ph_q + 2'h1;
        if (ph_q == 2'h1) sdo_d = 1'b0; // see (RQ4)
        if (ph_q == 2'h3) begin
          scl_d = 1'b0; st_d = SLBH_BYTE; bit_d = '0; n_d = '0; ph_d = '0;
          sh_d = rd_q ? ADDR_RD : ADDR_WR; // see (RQ5) see (RQ10)
        end
      end
      SLBH_BYTE: if (tick) begin
        ph_d = ph_q + 2'h1;
        unique case (ph_q)
          2'h0: begin
            if (bit_q <= BIT_LAST) sdo_d = (rd_q && n_q != 4'h0) ? 1'b1 : sh_q[7];
            else sdo_d = (rd_q && n_q != 4'h0) ? 1'b0 : 1'b1; // see (RQ13)
          end
          2'h1: scl_d = 1'b1;
          2'h2: begin
            if (bit_q <= BIT_LAST) sh_d = {sh_q[6:0], bus.sda};
            else if (!(rd_q && n_q != 4'h0) && bus.sda) nack_d = 1'b1;
          end
          2'h3: begin
            scl_d = 1'b0; bit_d = bit_q + 4'h1;
            if (bit_q == BIT_ACK) begin
              bit_d = '0; n_d = n_q + 4'h1;
              if (rd_q && n_q == 4'h1) cnt_d = sh_q; // see (RQ11)
              if (rd_q && n_q > 4'h1) rdat_d[(n_q - 4'h2) * 8 +: 8] = sh_q; // see (RQ12)
              if (!rd_q) begin
                sh_d = (n_q < 4'h2) ? 8'h00 : wd_q[7:0]; // see (RQ6) see (RQ7)
                if (n_q >= 4'h2) wd_d = {8'h00, wd_q[47:8]}; // see (RQ8)
              end
              if (nack_q || n_q == 4'(NUM_CFG + (rd_q ? 1 : 2))) st_d = SLBH_STOP;
            end
          end
          default: ;
        endcase
      end
      SLBH_STOP: if (tick) begin
        ph_d = ph_q + 2'h1;
        if (ph_q == 2'h0) sdo_d = 1'b0;
        if (ph_q == 2'h1) scl_d = 1'b1;
        if (ph_q == 2'h3) begin
          sdo_d = 1'b1; st_d = SLBH_END; // see (RQ9) see (RQ14)
        end
      end
      SLBH_END: if (tick) begin
        st_d = SLBH_IDLE; done_d = 1'b1;
      end
      default: st_d = SLBH_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= SLBH_IDLE; div_q <= '0; ph_q <= '0; bit_q <= '0; n_q <= '0; sh_q <= '0;
      rd_q <= 1'b0; scl_q <= 1'b1; sdo_q <= 1'b1; nack_q <= 1'b0; done_q <= 1'b0;
      wd_q <= '0; rdat_q <= '0; cnt_q <= '0;
    end else begin
      st_q <= st_d; div_q <= div_d; ph_q <= ph_d; bit_q <= bit_d; n_q <= n_d; sh_q <= sh_d;
      rd_q <= rd_d; scl_q <= scl_d; sdo_q <= sdo_d; nack_q <= nack_d; done_q <= done_d;
      wd_q <= wd_d; rdat_q <= rdat_d; cnt_q <= cnt_d;
    end
  end
  assign bus.scl      = scl_q;
  assign bus.sda_h_o  = 1'b0;
  assign bus.sda_h_oe = !sdo_q;
  assign o_busy       = (st_q != SLBH_IDLE);
  assign o_done       = done_q;
  assign o_nack       = nack_q;
  assign o_rdata      = rdat_q;
  assign o_rcount     = cnt_q;
endmodule // slbi_host

// ---- tb/slbi_props.sv ----
`timescale 1ns/1ps
module slbi_props
  import slbi_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_d_oe
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_q;
  logic [3:0] byt_q;
  logic [7:0] sh_q;
  logic [7:0] adr_q;
  logic [7:0] cnt_q;
  logic       st;
  logic       sp;
  logic       rs;
  logic       ack;
  assign st  = scl && scl_q && sda_q && !sda;
  assign sp  = scl && scl_q && !sda_q && sda;
  assign rs  = scl && !scl_q;
  assign ack = rs && (bit_q == BIT_ACK);
  // frame tracker: bit and byte position since the last start
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bit_q <= 4'h0;
      byt_q <= 4'h0;
      sh_q  <= 8'h00;
      adr_q <= 8'h00;
      cnt_q <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      cnt_q <= (scl != scl_q) ? 8'h00 : ((cnt_q == 8'hff) ? cnt_q : cnt_q + 8'h01);
      if (st) begin
        bit_q <= 4'h0;
        byt_q <= 4'h0;
      end else if (ack) begin
        bit_q <= 4'h0;
        byt_q <= byt_q + 4'h1;
        if (byt_q == 4'h0) adr_q <= sh_q;
      end else if (rs) begin
        bit_q <= bit_q + 4'h1;
        sh_q  <= {sh_q[6:0], sda};
      end
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  AST_ACK_WR:   assert property (ack && byt_q == 4'h0 && sh_q == ADDR_WR |-> !sda)
    else $error("write address not acknowledged");
  AST_ACK_RD:   assert property (ack && byt_q == 4'h0 && sh_q == ADDR_RD |-> !sda)
    else $error("read address not acknowledged");
  AST_ACK_DATA: assert property (ack && byt_q != 4'h0 && adr_q == ADDR_WR |-> !sda)
    else $error("write byte not acknowledged");
  AST_REL_ACK:  assert property (ack && byt_q != 4'h0 && adr_q == ADDR_RD |-> !sda_d_oe)
    else $error("device holds sda in host ack slot");
  AST_COUNT:    assert property (ack && byt_q == 4'h1 && adr_q == ADDR_RD |-> sh_q == BYTE_CNT)
    else $error("wrong byte count returned");
  AST_OE_STABLE: assert property (scl && scl_q |-> $stable(sda_d_oe))
    else $error("device moved sda while scl high");
  AST_STOP_REL: assert property (sp |-> !sda_d_oe [*8])
    else $error("device drives sda after stop");
  AST_SCL_LOW:  assert property (rs |-> cnt_q >= 8'h6e)
    else $error("scl low phase too short");
  cover property (ack && byt_q == 4'h8 && adr_q == ADDR_WR);
  cover property (ack && byt_q == 4'h1 && adr_q == ADDR_RD);
  cover property (sp);
endmodule // slbi_props

// ---- tb/slbi_tb_top.sv ----
`timescale 1ns/1ps
module slbi_tb_top
  import slbi_pkg::*;
();
  logic               i_clock;
  logic               i_arst_n;
  logic [STRAP_W-1:0] strap;
  logic [STRAP_W-1:0] clk_src;
  logic [STRAP_W-1:0] pin_out;
  logic [STRAP_W-1:0] pin_oe;
  logic [STRAP_W-1:0] strap_q;
  logic [47:0]        cfg;
  logic               go;
  slbi_op_t           op;
  logic [47:0]        wdata;
  logic               busy;
  logic               done;
  logic               nack;
  logic [47:0]        rdata;
  logic [7:0]         rcount;
  int                 err_count;
  int                 compares;

  slbi_if bus_i ();
  slbi_device slbi_device_i (.i_clock(i_clock), .i_arst_n(i_arst_n), .bus(bus_i), .i_strap_pin(strap),
    .i_clk_src(clk_src), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_strap(strap_q), .o_cfg(cfg));
  slbi_host slbi_host_i (.i_clock(i_clock), .i_arst_n(i_arst_n), .bus(bus_i), .i_go(go), .i_op(op),
    .i_wdata(wdata), .o_busy(busy), .o_done(done), .o_nack(nack), .o_rdata(rdata), .o_rcount(rcount));
  slbi_props slbi_props_i (.i_clock(i_clock), .i_arst_n(i_arst_n), .scl(bus_i.scl), .sda(bus_i.sda),
    .sda_d_oe(bus_i.sda_d_oe));

  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // reset with straps s, then pins turn to outputs driving the clock sources
  task automatic do_reset(input logic [4:0] s);
    @(negedge i_clock);
    i_arst_n = 1'b0;
    strap = s;
    repeat (3) @(negedge i_clock);
    chk(pin_oe, 5'h00);
    chk(cfg, CFG_RESET);
    i_arst_n = 1'b1;
    repeat (4) @(negedge i_clock);
    chk(strap_q, s);
    chk(pin_oe, 5'h1f);
    chk(pin_out, clk_src);
    strap = ~s;
    repeat (2) @(negedge i_clock);
    chk(strap_q, s);
  endtask

  task automatic xfer(input slbi_op_t o, input logic [47:0] d);
    int n;
    @(negedge i_clock);
    go = 1'b1;
    op = o;
    wdata = d;
    @(negedge i_clock);
    go = 1'b0;
    n = 0;
    while (done !== 1'b1) begin
      @(negedge i_clock);
      n++;
      if (n > 30000) begin
        err_count++;
        $display("BAD %0t transfer hung", $time);
        give_verdict();
      end
    end
  endtask

  initial begin
    i_arst_n = 1'b0;
    go = 1'b0;
    op = SLBI_OP_WRITE;
    wdata = 48'h0;
    strap = 5'h00;
    clk_src = 5'h0a;
    err_count = 0;
    compares = 0;
    do_reset(5'h15);
    xfer(SLBI_OP_READ, 48'h0);
    chk(rdata, CFG_RESET);
    chk(rcount, BYTE_CNT);
    chk(nack, 1'b0);
    xfer(SLBI_OP_WRITE, 48'ha5c3_0f1e_7781);
    chk(cfg, 48'ha5c3_0f1e_7781);
    chk(nack, 1'b0);
    xfer(SLBI_OP_WRITE, 48'h5a3c_f0e1_887e);
    chk(cfg, 48'h5a3c_f0e1_887e);
    xfer(SLBI_OP_READ, 48'h0);
    chk(rdata, 48'h5a3c_f0e1_887e);
    do_reset(5'h0a);
    give_verdict();
  end
endmodule // slbi_tb_top
